// >>> emr_pkg.sv
// Purpose: constants and types shared by the error manager block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: register offsets are local choices
package emr_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CARRY = 8'h04;
   localparam logic [7:0] ADDR_SINGLE = 8'h08;
   localparam logic [7:0] ADDR_MULTI = 8'h0c;
   localparam logic [7:0] ADDR_WDT_CNT = 8'h10;
   localparam logic [7:0] ADDR_PAR_CNT = 8'h14;
   localparam logic [7:0] ADDR_FLASH_CNT = 8'h18;
   localparam logic [7:0] ADDR_MASS_CNT = 8'h1c;
   localparam logic [7:0] ADDR_CONTROL = 8'h20;
   localparam logic [7:0] ADDR_BOOT = 8'h24;
   localparam logic [7:0] ADDR_SOFT_RESET = 8'h28;
   localparam logic [7:0] ADDR_MANUAL_CNT = 8'h2c;
   // ==========================================
   // status bit positions
   localparam int ST_IRQ = 0;
   localparam int ST_MANUAL = 1;
   localparam int ST_WDT = 2;
   localparam int ST_CRIT_SINGLE = 3;
   localparam int ST_CRIT_MULTI = 4;
   localparam int ST_NONCRIT_SINGLE = 5;
   localparam int ST_NONCRIT_MULTI = 6;
   localparam int ST_PARITY = 7;
   localparam int ST_MEMCLR = 9;
   localparam int ST_POWER = 10;
   localparam int ST_PULSE = 11;
   localparam int ST_WIDTH = 12;
   // carry bit positions, same order as the seven cause bits of the status register above
   localparam int CF_MANUAL = 1;
   localparam int CF_WDT = 2;
   localparam int CF_SINGLE = 3;
   localparam int CF_MULTI = 4;
   localparam int CF_NONCRIT_SINGLE = 5;
   localparam int CF_NONCRIT_MULTI = 6;
   localparam int CF_PARITY = 7;
   localparam int CF_WIDTH = 8;
   // field positions
   localparam int CNT_W = 4;
   localparam int HI_LSB = 16;
   localparam int CTL_SCRUB = 0;
   localparam int CTL_SOFT_EN = 1;
   localparam int CTL_POWER_EN = 2;
   localparam int BOOT_W = 3;
   localparam int RUN_LSB = 16;
   // ==========================================
   // reset values and highest boot code
   localparam logic [2:0] BOOT_RESET = 3'h0;
   localparam logic [2:0] BOOT_MAX = 3'h5;
   localparam logic SCRUB_RESET = 1'b1;
   localparam logic SOFT_EN_RESET = 1'b0;
   localparam logic POWER_EN_RESET = 1'b1;

   // counter indices
   typedef enum logic [2:0] {
      CNT_WDT = 3'h0,
      CNT_PARITY = 3'h1,
      CNT_FLASH_CORR = 3'h2,
      CNT_FLASH_UNCORR = 3'h3,
      CNT_MASS_CORR = 3'h4,
      CNT_MASS_UNCORR = 3'h5,
      CNT_MANUAL = 3'h6,
      CNT_SPARE = 3'h7
   } emr_cnt_type;

   // error events from the surrounding system, one-cycle pulses
   typedef struct packed {
      logic watchdog;
      logic parity;
      logic flash_corr;
      logic flash_uncorr;
      logic mass_corr;
      logic mass_uncorr;
      logic crit_single;
      logic crit_multi;
      logic noncrit_single;
      logic noncrit_multi;
      logic manual;
   } emr_events_type;

   // reset causes presented at the release of a system reset
   typedef struct packed {
      logic watchdog;
      logic manual;
      logic parity;
      logic crit_single;
      logic crit_multi;
      logic noncrit_single;
      logic noncrit_multi;
   } emr_causes_type;
endpackage : emr_pkg

// >>> emr_error_manager.sv
// Purpose: error manager - reset causes, error counters, boot select and enables
// Assumes: classic wishbone slave, single clock, inputs synchronous to clk_i
// Notes: counters and sticky flags are reset only by rst_i, not by the system reset they record
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module emr_error_manager (
   input wire logic clk_i, // 100 MHz system clock
   input wire logic rst_i, // synchronous power-on reset, active high
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write enable
   input wire logic [7:0] wb_adr_i, // wishbone byte address
   input wire logic [3:0] wb_sel_i, // wishbone byte selects
   input wire logic [31:0] wb_dat_i, // wishbone write data
   output logic [31:0] wb_dat_o, // wishbone read data
   output logic wb_ack_o, // wishbone acknowledge
   output logic wb_err_o, // wishbone error on unmapped address
   input wire emr_pkg::emr_events_type events_i, // error event pulses
   input wire logic cause_valid_i, // pulse: reset causes below are valid
   input wire emr_pkg::emr_causes_type causes_i, // cause of the last system reset
   input wire logic pulse_cmd_i, // pulse command seen
   input wire logic power_loss_i, // power loss signal
   input wire logic memory_cleared_i, // scrubber memory cleared level
   input wire logic [2:0] running_image_i, // image now running
   output logic [2:0] next_boot_image_select_o, // image to load on reboot
   output logic scrubber_enable_o, // scrubber on
   output logic power_loss_enable_o, // power loss detection on
   output logic software_reset_o, // one-cycle system reset request
   output logic irq_o // interrupt pending level
);
   // ==========================================
   // bus decode
   logic req;
   logic wr;
   logic hit;
   logic [31:0] rdata;
   logic [31:0] wmask;
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign wr = req & wb_we_i & hit;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   logic [31:0] wd;
   assign wd = wb_dat_i & wmask;

   // ==========================================
   // counters
   logic [emr_pkg::CNT_W-1:0] cnt [8];
   logic [7:0] cnt_event;
   logic [7:0] cnt_load;
   logic [emr_pkg::CNT_W-1:0] cnt_wdata [8];
   logic [7:0] cnt_wrap;

   always_comb
   begin
      cnt_event = '0;
      cnt_event[emr_pkg::CNT_WDT] = events_i.watchdog;
      cnt_event[emr_pkg::CNT_PARITY] = events_i.parity;
      cnt_event[emr_pkg::CNT_FLASH_CORR] = events_i.flash_corr;
      cnt_event[emr_pkg::CNT_FLASH_UNCORR] = events_i.flash_uncorr;
      cnt_event[emr_pkg::CNT_MASS_CORR] = events_i.mass_corr;
      cnt_event[emr_pkg::CNT_MASS_UNCORR] = events_i.mass_uncorr;
      cnt_event[emr_pkg::CNT_MANUAL] = events_i.manual;
   end

   // each counter register holds one counter in bits 3:0, or two in 3:0 and 19:16
   always_comb
   begin
      cnt_load = '0;
      for (int i = 0; i < 8; i++)
      begin
         cnt_wdata[i] = wb_dat_i[emr_pkg::CNT_W-1:0];
      end
      cnt_wdata[emr_pkg::CNT_FLASH_UNCORR] = wb_dat_i[emr_pkg::HI_LSB +: emr_pkg::CNT_W];
      cnt_wdata[emr_pkg::CNT_MASS_UNCORR] = wb_dat_i[emr_pkg::HI_LSB +: emr_pkg::CNT_W];
      if (wr)
      begin
         case (wb_adr_i)
            emr_pkg::ADDR_WDT_CNT: cnt_load[emr_pkg::CNT_WDT] = wb_sel_i[0];
            emr_pkg::ADDR_PAR_CNT: cnt_load[emr_pkg::CNT_PARITY] = wb_sel_i[0];
            emr_pkg::ADDR_MANUAL_CNT: cnt_load[emr_pkg::CNT_MANUAL] = wb_sel_i[0];
            emr_pkg::ADDR_FLASH_CNT:
            begin
               cnt_load[emr_pkg::CNT_FLASH_CORR] = wb_sel_i[0];
               cnt_load[emr_pkg::CNT_FLASH_UNCORR] = wb_sel_i[2];
            end
            emr_pkg::ADDR_MASS_CNT:
            begin
               cnt_load[emr_pkg::CNT_MASS_CORR] = wb_sel_i[0];
               cnt_load[emr_pkg::CNT_MASS_UNCORR] = wb_sel_i[2];
            end
            default: cnt_load = '0;
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_cnt
         // a load wins over an event in the same cycle: software owns the value it writes
         assign cnt_wrap[g] = cnt_event[g] & ~cnt_load[g] & (&cnt[g]);
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               cnt[g] <= '0;
            else if (cnt_load[g])
               cnt[g] <= cnt_wdata[g];
            else if (cnt_event[g])
               cnt[g] <= cnt[g] + 4'h1;
         end
      end
   endgenerate

   // sdram edac counters: single and multiple, critical and noncritical
   logic [emr_pkg::CNT_W-1:0] crit_single_count;
   logic [emr_pkg::CNT_W-1:0] noncrit_single_count;
   logic [emr_pkg::CNT_W-1:0] crit_multi_count;
   logic [emr_pkg::CNT_W-1:0] noncrit_multi_count;
   logic [3:0] edac_wrap;
   logic wr_single;
   logic wr_multi;
   assign wr_single = wr & (wb_adr_i == emr_pkg::ADDR_SINGLE);
   assign wr_multi = wr & (wb_adr_i == emr_pkg::ADDR_MULTI);
   assign edac_wrap[0] = events_i.crit_single & ~(wr_single & wb_sel_i[0]) & (&crit_single_count);
   assign edac_wrap[1] = events_i.crit_multi & ~(wr_multi & wb_sel_i[0]) & (&crit_multi_count);
   assign edac_wrap[2] = events_i.noncrit_single & ~(wr_single & wb_sel_i[2]) & (&noncrit_single_count);
   assign edac_wrap[3] = events_i.noncrit_multi & ~(wr_multi & wb_sel_i[2]) & (&noncrit_multi_count);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         crit_single_count <= '0;
         noncrit_single_count <= '0;
      end
      else
      begin
         if (wr_single & wb_sel_i[0])
            crit_single_count <= wb_dat_i[emr_pkg::CNT_W-1:0];
         else if (events_i.crit_single)
            crit_single_count <= crit_single_count + 4'h1;
         if (wr_single & wb_sel_i[2])
            noncrit_single_count <= wb_dat_i[emr_pkg::HI_LSB +: emr_pkg::CNT_W];
         else if (events_i.noncrit_single)
            noncrit_single_count <= noncrit_single_count + 4'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         crit_multi_count <= '0;
         noncrit_multi_count <= '0;
      end
      else
      begin
         if (wr_multi & wb_sel_i[0])
            crit_multi_count <= wb_dat_i[emr_pkg::CNT_W-1:0];
         else if (events_i.crit_multi)
            crit_multi_count <= crit_multi_count + 4'h1;
         if (wr_multi & wb_sel_i[2])
            noncrit_multi_count <= wb_dat_i[emr_pkg::HI_LSB +: emr_pkg::CNT_W];
         else if (events_i.noncrit_multi)
            noncrit_multi_count <= noncrit_multi_count + 4'h1;
      end
   end

   // ==========================================
   // carry flags: set wins over write-one clear
   logic [emr_pkg::CF_WIDTH-1:0] carry;
   logic [emr_pkg::CF_WIDTH-1:0] carry_set;
   logic [emr_pkg::CF_WIDTH-1:0] carry_clr;
   always_comb
   begin
      carry_set = '0;
      carry_set[emr_pkg::CF_WDT] = cnt_wrap[emr_pkg::CNT_WDT];
      carry_set[emr_pkg::CF_PARITY] = cnt_wrap[emr_pkg::CNT_PARITY];
      carry_set[emr_pkg::CF_MANUAL] = cnt_wrap[emr_pkg::CNT_MANUAL];
      carry_set[emr_pkg::CF_SINGLE] = edac_wrap[0];
      carry_set[emr_pkg::CF_MULTI] = edac_wrap[1];
      carry_set[emr_pkg::CF_NONCRIT_SINGLE] = edac_wrap[2];
      carry_set[emr_pkg::CF_NONCRIT_MULTI] = edac_wrap[3];
   end
   assign carry_clr = (wr && wb_adr_i == emr_pkg::ADDR_CARRY) ? wd[emr_pkg::CF_WIDTH-1:0] : '0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         carry <= '0;
      else
         carry <= ((carry & ~carry_clr) | carry_set) & {{(emr_pkg::CF_WIDTH-1){1'b1}}, 1'b0};
   end

   // ==========================================
   // status register
   logic [emr_pkg::ST_WIDTH-1:0] status;
   logic [emr_pkg::ST_WIDTH-1:0] status_set;
   logic [emr_pkg::ST_WIDTH-1:0] status_clr;
   logic power_loss_q;
   logic power_loss_edge;
   logic irq_event;

   // power loss only counts while detection is enabled
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         power_loss_q <= 1'b0;
      else
         power_loss_q <= power_loss_i;
   end
   assign power_loss_edge = power_loss_i & ~power_loss_q & power_loss_enable_o;
   assign irq_event = power_loss_edge | events_i.noncrit_multi;

   always_comb
   begin
      status_set = '0;
      status_set[emr_pkg::ST_PULSE] = pulse_cmd_i;
      status_set[emr_pkg::ST_POWER] = power_loss_edge;
      status_set[emr_pkg::ST_IRQ] = irq_event;
      if (cause_valid_i)
      begin
         status_set[emr_pkg::ST_PARITY] = causes_i.parity;
         status_set[emr_pkg::ST_NONCRIT_MULTI] = causes_i.noncrit_multi;
         status_set[emr_pkg::ST_NONCRIT_SINGLE] = causes_i.noncrit_single;
         status_set[emr_pkg::ST_CRIT_MULTI] = causes_i.crit_multi;
         status_set[emr_pkg::ST_CRIT_SINGLE] = causes_i.crit_single;
         status_set[emr_pkg::ST_WDT] = causes_i.watchdog;
         status_set[emr_pkg::ST_MANUAL] = causes_i.manual;
      end
   end
   assign status_clr = (wr && wb_adr_i == emr_pkg::ADDR_STATUS) ? wd[emr_pkg::ST_WIDTH-1:0] : '0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         status <= '0;
      else
      begin
         status <= (status & ~status_clr) | status_set;
         // bit 9 follows the scrubber, bit 8 reserved
         status[emr_pkg::ST_MEMCLR] <= memory_cleared_i;
         status[emr_pkg::ST_MEMCLR-1] <= 1'b0;
      end
   end
   assign irq_o = status[emr_pkg::ST_IRQ];

   // ==========================================
   // control: scrubber, soft reset and power loss enables, boot image
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         scrubber_enable_o <= emr_pkg::SCRUB_RESET;
         power_loss_enable_o <= emr_pkg::POWER_EN_RESET;
      end
      else if (wr && wb_adr_i == emr_pkg::ADDR_CONTROL && wb_sel_i[0])
      begin
         scrubber_enable_o <= wb_dat_i[emr_pkg::CTL_SCRUB];
         power_loss_enable_o <= wb_dat_i[emr_pkg::CTL_POWER_EN];
      end
   end

   logic soft_reset_enable;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         soft_reset_enable <= emr_pkg::SOFT_EN_RESET;
      else if (wr && wb_adr_i == emr_pkg::ADDR_CONTROL && wb_sel_i[0])
         soft_reset_enable <= wb_dat_i[emr_pkg::CTL_SOFT_EN];
   end

   // codes above 0x5 name no image, so such writes are dropped
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         next_boot_image_select_o <= emr_pkg::BOOT_RESET;
      else if (wr && wb_adr_i == emr_pkg::ADDR_BOOT && wb_sel_i[0] &&
               wb_dat_i[emr_pkg::BOOT_W-1:0] <= emr_pkg::BOOT_MAX)
         next_boot_image_select_o <= wb_dat_i[emr_pkg::BOOT_W-1:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         software_reset_o <= 1'b0;
      else
         software_reset_o <= wr && wb_adr_i == emr_pkg::ADDR_SOFT_RESET && wb_sel_i[0] &&
                             wb_dat_i[0] && soft_reset_enable;
   end

   // ==========================================
   // read mux and answer
   always_comb
   begin
      hit = 1'b1;
      rdata = '0;
      case (wb_adr_i)
         emr_pkg::ADDR_STATUS: rdata[emr_pkg::ST_WIDTH-1:0] = status;
         emr_pkg::ADDR_CARRY: rdata[emr_pkg::CF_WIDTH-1:0] = carry;
         emr_pkg::ADDR_SINGLE:
         begin
            rdata[emr_pkg::CNT_W-1:0] = crit_single_count;
            rdata[emr_pkg::HI_LSB +: emr_pkg::CNT_W] = noncrit_single_count;
         end
         emr_pkg::ADDR_MULTI:
         begin
            rdata[emr_pkg::CNT_W-1:0] = crit_multi_count;
            rdata[emr_pkg::HI_LSB +: emr_pkg::CNT_W] = noncrit_multi_count;
         end
         emr_pkg::ADDR_WDT_CNT: rdata[emr_pkg::CNT_W-1:0] = cnt[emr_pkg::CNT_WDT];
         emr_pkg::ADDR_PAR_CNT: rdata[emr_pkg::CNT_W-1:0] = cnt[emr_pkg::CNT_PARITY];
         emr_pkg::ADDR_MANUAL_CNT: rdata[emr_pkg::CNT_W-1:0] = cnt[emr_pkg::CNT_MANUAL];
         emr_pkg::ADDR_FLASH_CNT:
         begin
            rdata[emr_pkg::CNT_W-1:0] = cnt[emr_pkg::CNT_FLASH_CORR];
            rdata[emr_pkg::HI_LSB +: emr_pkg::CNT_W] = cnt[emr_pkg::CNT_FLASH_UNCORR];
         end
         emr_pkg::ADDR_MASS_CNT:
         begin
            rdata[emr_pkg::CNT_W-1:0] = cnt[emr_pkg::CNT_MASS_CORR];
            rdata[emr_pkg::HI_LSB +: emr_pkg::CNT_W] = cnt[emr_pkg::CNT_MASS_UNCORR];
         end
         emr_pkg::ADDR_CONTROL:
         begin
            rdata[emr_pkg::CTL_SCRUB] = scrubber_enable_o;
            rdata[emr_pkg::CTL_SOFT_EN] = soft_reset_enable;
            rdata[emr_pkg::CTL_POWER_EN] = power_loss_enable_o;
         end
         emr_pkg::ADDR_BOOT:
         begin
            rdata[emr_pkg::BOOT_W-1:0] = next_boot_image_select_o;
            rdata[emr_pkg::RUN_LSB +: emr_pkg::BOOT_W] = running_image_i;
         end
         emr_pkg::ADDR_SOFT_RESET: rdata = '0;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= '0;
      end
      else
      begin
         wb_ack_o <= req & hit;
         wb_err_o <= req & ~hit;
         wb_dat_o <= (req & hit & ~wb_we_i) ? rdata : '0;
      end
   end
endmodule : emr_error_manager

// >>> emr_error_manager_asserts.sv
// Purpose: port-level property checks for the error manager
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every emr_error_manager instance
`timescale 1ns/1ps
module emr_error_manager_asserts (
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [7:0] wb_adr_i, // address
   input wire logic [3:0] wb_sel_i, // selects
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic [31:0] wb_dat_o, // read data
   input wire logic wb_ack_o, // ack
   input wire logic wb_err_o, // error
   input wire emr_pkg::emr_events_type events_i, // events
   input wire logic power_loss_i, // power loss
   input wire logic power_loss_enable_o, // detection on
   input wire logic [2:0] next_boot_image_select_o, // boot select
   input wire logic software_reset_o, // reset request
   input wire logic irq_o // interrupt
);
   // ==========================================
   // helpers
   logic take, boot_take, soft_take, soft_en;
   logic [2:0] boot_dat;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign boot_take = take && wb_we_i && wb_adr_i == emr_pkg::ADDR_BOOT && wb_sel_i[0] && wb_dat_i[2:0] <= 3'h5;
   assign soft_take = take && wb_we_i && wb_adr_i == emr_pkg::ADDR_SOFT_RESET && wb_sel_i[0] && wb_dat_i[0] && soft_en;
   always_ff @(posedge clk_i) boot_dat <= wb_dat_i[2:0];
   // soft reset enable as software last wrote it, rebuilt from bus traffic alone
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         soft_en <= emr_pkg::SOFT_EN_RESET;
      else if (take && wb_we_i && wb_adr_i == emr_pkg::ADDR_CONTROL && wb_sel_i[0])
         soft_en <= wb_dat_i[emr_pkg::CTL_SOFT_EN];
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================
   // properties
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_mapped_ack: assert property (take && wb_adr_i <= 8'h2c && wb_adr_i[1:0] == 2'h0 |=> wb_ack_o && !wb_err_o)
      else $error("mapped access not acknowledged next cycle");
   a_unmapped_err: assert property (take && wb_adr_i > 8'h2c |=> wb_err_o && !wb_ack_o)
      else $error("unmapped access not refused");
   a_no_stray_answer: assert property (wb_ack_o || wb_err_o |-> $past(take))
      else $error("answer without a request");
   a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_power_irq: assert property (power_loss_enable_o && $rose(power_loss_i) |-> ##[1:2] irq_o)
      else $error("power loss did not raise interrupt");
   a_edac_irq: assert property (events_i.noncrit_multi |-> ##[1:2] irq_o)
      else $error("noncritical multiple error did not raise interrupt");
   a_soft_gated: assert property (software_reset_o |-> $past(soft_take))
      else $error("software reset without an enabled request");
   a_soft_fire: assert property (soft_take |=> software_reset_o)
      else $error("enabled software reset request not carried out");
   a_boot_load: assert property (boot_take |=> next_boot_image_select_o == boot_dat)
      else $error("boot select not loaded");
   a_boot_hold: assert property ($changed(next_boot_image_select_o) |-> $past(boot_take))
      else $error("boot select changed without a legal write");
   c_boot: cover property (boot_take);
   c_soft: cover property (software_reset_o);
   c_err: cover property (wb_err_o);
endmodule : emr_error_manager_asserts

bind emr_error_manager emr_error_manager_asserts u_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .events_i(events_i), .power_loss_i(power_loss_i),
   .power_loss_enable_o(power_loss_enable_o), .next_boot_image_select_o(next_boot_image_select_o),
   .software_reset_o(software_reset_o), .irq_o(irq_o));

// >>> emr_error_manager_test.sv
// Purpose: self-checking bench for the error manager
// Assumes: classic wishbone, answer one cycle after the request is taken
// Notes: the watchdog counter is loaded with 15 so it wraps at once; the other counters get random values
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module emr_error_manager_test;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, cause_valid_i, pulse_cmd_i;
   logic power_loss_i, memory_cleared_i, scrubber_enable_o, power_loss_enable_o, software_reset_o, irq_o, er;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [2:0] running_image_i, next_boot_image_select_o;
   emr_pkg::emr_events_type events_i;
   emr_pkg::emr_causes_type causes_i;
   int failures = 0;
   int checks_done = 0;
   int sr_seen = 0;
   int seed = 32'h47a6;
   // counter table in event order from the msb: address, field lsb, carry bit (0 = none)
   logic [7:0] adr_t [11] = '{8'h10, 8'h14, 8'h18, 8'h18, 8'h1c, 8'h1c, 8'h08, 8'h0c, 8'h08, 8'h0c, 8'h2c};
   int lsb_t [11] = '{0, 0, 0, 16, 0, 16, 0, 0, 16, 16, 0};
   int cb_t [11] = '{2, 7, 0, 0, 0, 0, 3, 4, 5, 6, 1};
   emr_error_manager dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .wb_err_o, .events_i, .cause_valid_i, .causes_i, .pulse_cmd_i, .power_loss_i,
      .memory_cleared_i, .running_image_i, .next_boot_image_select_o, .scrubber_enable_o, .power_loss_enable_o,
      .software_reset_o, .irq_o);
   // ==========================================
   // bus and check helpers
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, sel, dat};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      rd = wb_dat_o;
      er = wb_err_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
   endtask : wb
   task automatic rdc(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, adr, 32'h0, 4'hf);
      `CHK(rd & m, e)
   endtask : rdc
   function automatic logic [31:0] cause_bits(input logic [6:0] c);
      return {24'h0, c[4], c[0], c[1], c[2], c[3], c[6], c[5], 1'b0};
   endfunction : cause_bits
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (software_reset_o === 1'b1) sr_seen++;
   // whole run is a few hundred cycles; this limit only catches a hang
   initial
   begin
      #200000;
      failures++;
      report_and_stop();
   end
   initial
   begin
      int v, n, k;
      logic [6:0] c;
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {events_i, cause_valid_i, causes_i, pulse_cmd_i, power_loss_i, memory_cleared_i} = '0;
      running_image_i = 3'h2;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(8'h00, 32'hffffffff, 32'h0);
      rdc(8'h04, 32'hffffffff, 32'h0);
      rdc(8'h20, 32'h7, 32'h5);
      rdc(8'h24, 32'h70007, 32'h20000);
      $display("test reset done");
      for (int i = 0; i < 11; i++)
      begin
         v = (i == 0) ? 15 : $random(seed) & 15;
         n = (i == 0) ? 1 : ($random(seed) & 15) + 1;
         wb(1'b1, adr_t[i], 32'(v) << lsb_t[i], lsb_t[i] == 0 ? 4'h1 : 4'h4);
         @(posedge clk_i);
         events_i <= emr_pkg::emr_events_type'(11'h1 << (10 - i));
         repeat (n) @(posedge clk_i);
         events_i <= '0;
         rdc(adr_t[i], 32'hf << lsb_t[i], 32'(v + n & 15) << lsb_t[i]);
         `CHK(rd[lsb_t[i] +: 4], 4'(v + n))
         if (cb_t[i] != 0)
         begin
            rdc(8'h04, 32'h1 << cb_t[i], 32'(v + n > 15) << cb_t[i]);
            wb(1'b1, 8'h04, 32'h1 << cb_t[i], 4'h1);
            rdc(8'h04, 32'hff, 32'h0);
         end
      end
      `CHK(irq_o, 1'b1)
      wb(1'b1, 8'h00, 32'h0, 4'h1);
      rdc(8'h00, 32'h1, 32'h1);
      wb(1'b1, 8'h00, 32'h1, 4'h1);
      rdc(8'h00, 32'h1, 32'h0);
      `CHK(irq_o, 1'b0)
      $display("test counters done");
      for (k = 0; k < 2; k++)
      begin
         c = (k == 0) ? 7'h7f : 7'($random(seed));
         @(posedge clk_i);
         {cause_valid_i, causes_i} <= {1'b1, c};
         @(posedge clk_i);
         cause_valid_i <= 1'b0;
         rdc(8'h00, 32'hfe, cause_bits(c));
         wb(1'b1, 8'h00, 32'hff, 4'h1);
         rdc(8'h00, 32'hff, 32'h0);
      end
      memory_cleared_i <= 1'b1;
      pulse_cmd_i <= 1'b1;
      @(posedge clk_i);
      pulse_cmd_i <= 1'b0;
      wb(1'b1, 8'h00, 32'h200, 4'h2);
      rdc(8'h00, 32'ha00, 32'ha00);
      wb(1'b1, 8'h00, 32'h800, 4'h2);
      rdc(8'h00, 32'ha00, 32'h200);
      power_loss_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK(irq_o, 1'b1)
      rdc(8'h00, 32'h401, 32'h401);
      wb(1'b1, 8'h00, 32'h401, 4'h3);
      rdc(8'h00, 32'h401, 32'h0);
      power_loss_i <= 1'b0;
      wb(1'b1, 8'h20, 32'h1, 4'h1);
      power_loss_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rdc(8'h00, 32'h401, 32'h0);
      `CHK(power_loss_enable_o, 1'b0)
      $display("test status done");
      for (k = 0; k < 8; k++)
      begin
         wb(1'b1, 8'h24, 32'(k), 4'h1);
         v = (k <= 5) ? k : 5;
         rdc(8'h24, 32'h7, 32'(v));
         `CHK(next_boot_image_select_o, 3'(v))
      end
      v = $unsigned($random(seed)) % 6;
      running_image_i <= 3'(v);
      rdc(8'h24, 32'h70000, 32'(v) << 16);
      wb(1'b1, 8'h28, 32'h1, 4'h1);
      repeat (2) @(posedge clk_i);
      `CHK(sr_seen, 0)
      wb(1'b1, 8'h20, 32'h3, 4'h1);
      wb(1'b1, 8'h28, 32'h1, 4'h1);
      repeat (2) @(posedge clk_i);
      `CHK(sr_seen, 1)
      `CHK(scrubber_enable_o, 1'b1)
      wb(1'b1, 8'h20, 32'h4, 4'h1);
      rdc(8'h20, 32'h7, 32'h4);
      `CHK(scrubber_enable_o, 1'b0)
      wb(1'b0, 8'h30, 32'h0, 4'hf);
      `CHK(er, 1'b1)
      `CHK(rd, 32'h0)
      $display("test control done");
      report_and_stop();
   end
endmodule : emr_error_manager_test
